// ### hdl/position_sync_output_unit.sv
// Purpose: position synchronised compare output with wishbone registers
// Assumes: position count pulses come from logic on mclk
// Notes:   attribute is handed out raw, output shaping lives elsewhere
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module position_sync_output_unit
    import pso_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pso_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [pso_pkg::DATA_W-1:0] wb_dat_i,
    output logic [pso_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // position count
    input wire logic pos_up,
    input wire logic pos_down,
    // compare output
    output logic compare_out_en,
    output logic compare_pulse,
    output logic [pso_pkg::ATTR_W-1:0] compare_attr,
    output logic [pso_pkg::POS_W-1:0] current_position,
    // interrupt
    output logic irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    point_table_if tbl ();

    logic ack;
    logic [DATA_W-1:0] dat;
    logic [15:0] ctrl;
    logic [15:0] adjust_val;
    logic [POS_W-1:0] origin_bias;
    logic [1:0] mode;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    cmp_state_t state;
    logic [SLOT_W-1:0] point;
    logic [POS_W-1:0] cur_pos;
    logic origin_done;
    logic adjust_done;
    logic [ATTR_W-1:0] attr_out;
    logic pulse_out;

    logic next_ack;
    logic [DATA_W-1:0] next_dat;
    logic [15:0] next_ctrl;
    logic [15:0] next_adjust_val;
    logic [POS_W-1:0] next_origin_bias;
    logic [1:0] next_mode;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] next_irq_mask;
    cmp_state_t next_state;
    logic [SLOT_W-1:0] next_point;
    logic [POS_W-1:0] next_cur_pos;
    logic next_origin_done;
    logic next_adjust_done;
    logic [ATTR_W-1:0] next_attr_out;
    logic next_pulse_out;

    logic req;
    logic wr;
    logic rd_take;
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] tbl_off;
    logic in_table;
    logic [DATA_W-1:0] old_word;
    logic [DATA_W-1:0] merged;
    logic [DATA_W-1:0] rdata;
    logic [15:0] rise;
    logic [IRQ_W-1:0] events;
    logic [POS_W-1:0] step;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [DATA_W-1:0] apply_sel(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [3:0] sel);
        logic [DATA_W-1:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                r[b*8 +: 8] = new_v[b*8 +: 8];
        end
        apply_sel = r;
    endfunction

    function automatic logic [DATA_W-1:0] zext16(input logic [15:0] v);
        zext16 = {16'h0000, v};
    endfunction

    point_table u_table
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .tbl(tbl)
    );

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign req = wb_cyc_i & wb_stb_i;
    assign idx = wb_adr_i[ADR_W-1:2];
    // write lands on the edge that the master sees ack
    assign wr = req & wb_we_i & ack;
    // read side effects go with the capture edge so no later event is lost
    assign rd_take = req & ~wb_we_i & ~ack;
    assign in_table = (idx >= IDX_POINT_BASE) && (idx < IDX_POINT_END);
    assign tbl_off = idx - IDX_POINT_BASE;

    assign tbl.rd_slot = tbl_off[SLOT_W:1];
    assign tbl.wr_slot = tbl_off[SLOT_W:1];
    assign tbl.wr_target = tbl_off[0];
    assign tbl.wr_en = wr & in_table;
    assign tbl.wr_data = merged;
    assign tbl.cmp_slot = point - FIRST_POINT;

    always_comb
    begin
        rdata = '0;
        if (in_table)
            rdata = tbl_off[0] ? tbl.rd_target : {29'h0, tbl.rd_attr};
        else
        begin
            case (idx)
                IDX_CONTROL: rdata = zext16(ctrl);
                IDX_ADJUST: rdata = zext16(adjust_val);
                IDX_STATUS: rdata = {29'h0, adjust_done, origin_done,
                    state == CMP_RUN};
                IDX_TARGET_POINT: rdata = {27'h0, point};
                IDX_POSITION: rdata = zext16(cur_pos[15:0]);
                IDX_ORIGIN_BIAS: rdata = origin_bias;
                IDX_MODE: rdata = {30'h0, mode};
                IDX_IRQ_STATUS: rdata = {28'h0, irq_status};
                IDX_IRQ_MASK: rdata = {28'h0, irq_mask};
                IDX_POSITION_FULL: rdata = cur_pos;
                default: rdata = '0;
            endcase
        end
    end

    // old value feeds the byte-lane merge of a partial write
    assign old_word = rdata;
    assign merged = apply_sel(old_word, wb_dat_i, wb_sel_i);

    // ----------------------------------------------------------------
    // bus answer
    // ----------------------------------------------------------------
    always_comb
    begin
        next_ack = req & ~ack;
        next_dat = dat;
        if (rd_take)
            next_dat = rdata;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack <= 1'b0;
            dat <= '0;
        end
        else
        begin
            ack <= next_ack;
            dat <= next_dat;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = dat;

    // ----------------------------------------------------------------
    // control, position and compare
    // ----------------------------------------------------------------
    assign step = POS_W'({1'b0, pos_up}) - POS_W'({1'b0, pos_down});

    always_comb
    begin
        next_ctrl = ctrl;
        next_adjust_val = adjust_val;
        next_origin_bias = origin_bias;
        next_mode = mode;
        next_irq_mask = irq_mask;
        next_state = state;
        next_point = point;
        next_cur_pos = cur_pos + step;
        next_origin_done = origin_done;
        next_adjust_done = adjust_done;
        next_attr_out = attr_out;
        next_pulse_out = 1'b0;
        events = '0;
        rise = '0;

        case (state)
            CMP_IDLE:
            begin
                next_point = point;
            end
            CMP_RUN:
            begin
                if (cur_pos == tbl.cmp_target)
                begin
                    next_attr_out = tbl.cmp_attr;
                    next_pulse_out = 1'b1;
                    events[IRQ_MATCH_BIT] = 1'b1;
                    if (mode[MODE_INCR_BIT])
                        next_cur_pos = POS_RESET;
                    if (point == LAST_POINT)
                    begin
                        events[IRQ_END_BIT] = 1'b1;
                        next_point = FIRST_POINT;
                        if (!mode[MODE_CYCLIC_BIT])
                            next_state = CMP_IDLE;
                    end
                    else
                        next_point = point + 5'h01;
                end
            end
            default:
            begin
                next_state = CMP_IDLE;
            end
        endcase

        if (wr)
        begin
            case (idx)
                IDX_CONTROL:
                begin
                    next_ctrl = merged[15:0];
                    // start, origin and adjust fire only on a 0-to-1 change of the bit; a 0 stops compare and clears done
                    rise = merged[15:0] & ~ctrl;
                    if (rise[CTRL_ENABLE_BIT])
                    begin
                        next_state = CMP_RUN;
                        next_point = FIRST_POINT;
                    end
                    if (!merged[CTRL_ENABLE_BIT])
                    begin
                        next_state = CMP_IDLE;
                        next_point = FIRST_POINT;
                    end
                    if (rise[CTRL_ADJUST_BIT])
                    begin
                        next_cur_pos = cur_pos + zext16(adjust_val);
                        next_adjust_done = 1'b1;
                        events[IRQ_ADJUST_BIT] = 1'b1;
                    end
                    if (!merged[CTRL_ADJUST_BIT])
                        next_adjust_done = 1'b0;
                    // origin load takes priority over an adjust in the same write
                    if (rise[CTRL_ORIGIN_BIT])
                    begin
                        next_cur_pos = origin_bias;
                        next_origin_done = 1'b1;
                        events[IRQ_ORIGIN_BIT] = 1'b1;
                    end
                    if (!merged[CTRL_ORIGIN_BIT])
                        next_origin_done = 1'b0;
                end
                IDX_ADJUST: next_adjust_val = merged[15:0];
                IDX_ORIGIN_BIAS: next_origin_bias = merged;
                IDX_MODE: next_mode = merged[1:0];
                IDX_IRQ_MASK: next_irq_mask = merged[IRQ_W-1:0];
                default: next_mode = mode;
            endcase
        end

        // clear on read, a new event in the same cycle still sets
        next_irq_status = irq_status;
        if (rd_take && (idx == IDX_IRQ_STATUS))
            next_irq_status = '0;
        next_irq_status = next_irq_status | events;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= CTRL_RESET;
            adjust_val <= ADJUST_RESET;
            origin_bias <= BIAS_RESET;
            mode <= MODE_RESET;
            irq_status <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            state <= CMP_IDLE;
            point <= FIRST_POINT;
            cur_pos <= POS_RESET;
            origin_done <= 1'b0;
            adjust_done <= 1'b0;
            attr_out <= ATTR_RESET;
            pulse_out <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            adjust_val <= next_adjust_val;
            origin_bias <= next_origin_bias;
            mode <= next_mode;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            state <= next_state;
            point <= next_point;
            cur_pos <= next_cur_pos;
            origin_done <= next_origin_done;
            adjust_done <= next_adjust_done;
            attr_out <= next_attr_out;
            pulse_out <= next_pulse_out;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign compare_out_en = (state == CMP_RUN);
    assign compare_pulse = pulse_out;
    assign compare_attr = attr_out;
    assign current_position = cur_pos;
    assign irq = |(irq_status & irq_mask);
endmodule

// ### common/pso_pkg.sv
// Purpose: shared constants and types of the position sync output unit
// Assumes: 32-bit classic wishbone, registers one word each at index * 4
// Notes:   point table holds points four to twenty
package pso_pkg;

    // ----------------------------------------------------------------
    // widths and point range
    // ----------------------------------------------------------------
    localparam int ADR_W = 18;
    localparam int IDX_W = 16;
    localparam int DATA_W = 32;
    localparam int POS_W = 32;
    localparam int ATTR_W = 3;
    localparam int SLOT_W = 5;
    localparam int NUM_POINTS = 17;
    localparam logic [SLOT_W-1:0] FIRST_POINT = 5'h04;
    localparam logic [SLOT_W-1:0] LAST_POINT = 5'h14;
    localparam logic [DATA_W-1:0] ATTR_MAX = 32'h0000_0006;

    // ----------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_CONTROL = 16'h30b0;
    localparam logic [IDX_W-1:0] IDX_ADJUST = 16'h30b1;
    localparam logic [IDX_W-1:0] IDX_STATUS = 16'h30c0;
    localparam logic [IDX_W-1:0] IDX_TARGET_POINT = 16'h30c1;
    localparam logic [IDX_W-1:0] IDX_POSITION = 16'h30c2;
    localparam logic [IDX_W-1:0] IDX_ORIGIN_BIAS = 16'h30d0;
    localparam logic [IDX_W-1:0] IDX_MODE = 16'h30d1;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 16'h30d2;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'h30d3;
    localparam logic [IDX_W-1:0] IDX_POSITION_FULL = 16'h30d4;
    localparam logic [IDX_W-1:0] IDX_POINT_BASE = 16'h3100;
    localparam logic [IDX_W-1:0] IDX_POINT_END = 16'h3122;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_ORIGIN_BIT = 1;
    localparam int CTRL_ADJUST_BIT = 2;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_ORIGIN_BIT = 1;
    localparam int STAT_ADJUST_BIT = 2;
    localparam int MODE_INCR_BIT = 0;
    localparam int MODE_CYCLIC_BIT = 1;
    localparam int IRQ_W = 4;
    localparam int IRQ_MATCH_BIT = 0;
    localparam int IRQ_END_BIT = 1;
    localparam int IRQ_ORIGIN_BIT = 2;
    localparam int IRQ_ADJUST_BIT = 3;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] ADJUST_RESET = 16'h0000;
    localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
    localparam logic [POS_W-1:0] BIAS_RESET = 32'h0000_0000;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
    localparam logic [ATTR_W-1:0] ATTR_RESET = 3'h0;

    typedef enum {CMP_IDLE, CMP_RUN} cmp_state_t;

endpackage

// ### common/point_table_if.sv
// Purpose: carries bus and compare accesses between core and point table
// Assumes: slots 0..16 stand for points four to twenty
// Notes:   reads are combinational, writes land on the next clock edge
`timescale 1ns/1ps
interface point_table_if;
    logic wr_en;
    logic wr_target;
    logic [pso_pkg::SLOT_W-1:0] wr_slot;
    logic [pso_pkg::DATA_W-1:0] wr_data;
    logic [pso_pkg::SLOT_W-1:0] rd_slot;
    logic [pso_pkg::ATTR_W-1:0] rd_attr;
    logic [pso_pkg::POS_W-1:0] rd_target;
    logic [pso_pkg::SLOT_W-1:0] cmp_slot;
    logic [pso_pkg::ATTR_W-1:0] cmp_attr;
    logic [pso_pkg::POS_W-1:0] cmp_target;

    modport table_side
    (
        input wr_en, wr_target, wr_slot, wr_data, rd_slot, cmp_slot,
        output rd_attr, rd_target, cmp_attr, cmp_target
    );
    modport core_side
    (
        output wr_en, wr_target, wr_slot, wr_data, rd_slot, cmp_slot,
        input rd_attr, rd_target, cmp_attr, cmp_target
    );
endinterface

// ### hdl/point_table.sv
// Purpose: attribute and target position store for points four to twenty
// Assumes: core hands over byte-merged write data
// Notes:   attribute writes above six are dropped, old value kept
`timescale 1ns/1ps
module point_table
    import pso_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // core access
    point_table_if.table_side tbl
);
    logic [ATTR_W-1:0] attr_mem [NUM_POINTS];
    logic [POS_W-1:0] target_mem [NUM_POINTS];
    logic [ATTR_W-1:0] next_attr_mem [NUM_POINTS];
    logic [POS_W-1:0] next_target_mem [NUM_POINTS];

    function automatic logic slot_ok(input logic [SLOT_W-1:0] s);
        slot_ok = (s < SLOT_W'(NUM_POINTS));
    endfunction

    always_comb
    begin
        next_attr_mem = attr_mem;
        next_target_mem = target_mem;
        if (tbl.wr_en && slot_ok(tbl.wr_slot))
        begin
            if (tbl.wr_target)
                next_target_mem[tbl.wr_slot] = tbl.wr_data;
            else if (tbl.wr_data <= ATTR_MAX)
                next_attr_mem[tbl.wr_slot] = tbl.wr_data[ATTR_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_POINTS; i++)
            begin
                attr_mem[i] <= ATTR_RESET;
                target_mem[i] <= POS_RESET;
            end
        end
        else
        begin
            attr_mem <= next_attr_mem;
            target_mem <= next_target_mem;
        end
    end

    assign tbl.rd_attr = slot_ok(tbl.rd_slot) ? attr_mem[tbl.rd_slot] : ATTR_RESET;
    assign tbl.rd_target = slot_ok(tbl.rd_slot) ? target_mem[tbl.rd_slot] : POS_RESET;
    assign tbl.cmp_attr = slot_ok(tbl.cmp_slot) ? attr_mem[tbl.cmp_slot] : ATTR_RESET;
    assign tbl.cmp_target = slot_ok(tbl.cmp_slot) ? target_mem[tbl.cmp_slot] : POS_RESET;
endmodule

// ### testbench/pso_assertions.sv
// Purpose: port-level checks of the position sync output unit
// Assumes: one clock domain, reset active low
// Notes: bound onto every instance of the unit
`timescale 1ns/1ps
module pso_checker
    import pso_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // bus and count
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic pos_up,
    input wire logic pos_down,
    // compare side
    input wire logic compare_out_en,
    input wire logic compare_pulse,
    input wire logic [pso_pkg::ATTR_W-1:0] compare_attr,
    input wire logic [pso_pkg::POS_W-1:0] current_position
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // register access and compare output
    // ----------------------------------------------------------------
    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack_once;
        s_taken |=> s_answer;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack not one cycle after request");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    property p_off_quiet;
        !compare_out_en |=> !compare_pulse;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("pulse while compare off");
    property p_start;
        $rose(compare_out_en) |-> $past(wb_ack_o && wb_we_i);
    endproperty
    a_start: assert property (p_start)
        else $error("compare started without a write");
    property p_stop;
        $fell(compare_out_en) |-> $past(wb_ack_o && wb_we_i) || compare_pulse;
    endproperty
    a_stop: assert property (p_stop)
        else $error("compare stopped without cause");
    property p_attr_hold;
        !compare_pulse |-> $stable(compare_attr);
    endproperty
    a_attr_hold: assert property (p_attr_hold)
        else $error("attribute moved without a match");
    property p_pos_hold;
        !pos_up && !pos_down && !wb_ack_o && !compare_out_en |=> $stable(current_position);
    endproperty
    a_pos_hold: assert property (p_pos_hold)
        else $error("position moved without cause");
    property p_pos_count;
        pos_up && !pos_down && !wb_ack_o && !compare_out_en
            |=> current_position == $past(current_position) + 32'h0000_0001;
    endproperty
    a_pos_count: assert property (p_pos_count)
        else $error("position did not count up by one");
endmodule
bind position_sync_output_unit pso_checker i_chk
(
    .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .pos_up(pos_up), .pos_down(pos_down),
    .compare_out_en(compare_out_en), .compare_pulse(compare_pulse),
    .compare_attr(compare_attr), .current_position(current_position)
);

// ### testbench/host_model.sv
// Purpose: host controller reaching the unit over classic wishbone
// Assumes: unit acks every request, sel always all bytes
// Notes: raises hang when an ack never comes
`timescale 1ns/1ps
module host_model
    import pso_pkg::*;
(
    // clock
    input wire logic mclk,
    // wishbone master
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [pso_pkg::ADR_W-1:0] adr,
    output logic [3:0] sel,
    output logic [pso_pkg::DATA_W-1:0] dat_w,
    input wire logic [pso_pkg::DATA_W-1:0] dat_r,
    input wire logic ack,
    // status
    output logic hang
);
    initial
    begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = '0;
        sel = 4'hf;
        dat_w = 32'h0000_0000;
        hang = 1'b0;
    end
    task automatic xfer(input logic w, input logic [IDX_W-1:0] idx,
        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        dat_w <= d;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
            hang <= 1'b1;
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        // let the landing edge settle before the caller looks at outputs
        #1;
    endtask
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] q;
        xfer(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [IDX_W-1:0] idx, output logic [DATA_W-1:0] q);
        xfer(1'b0, idx, 32'h0000_0000, q);
    endtask
    // start, origin and adjust fire on a rising bit only, so clear first
    task automatic trig(input int b);
        wr(IDX_CONTROL, 32'h0000_0000);
        wr(IDX_CONTROL, 32'h0000_0001 << b);
    endtask
endmodule

// ### testbench/testbench.sv
// Purpose: self-checking bench of the position sync output unit
// Assumes: host model speaks the bus, bench drives count pulses
// Notes: one down pulse checks the count direction, up pulses drive matches
`timescale 1ns/1ps
module testbench;
    import pso_pkg::*;
    logic mclk;
    logic rst_n;
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [DATA_W-1:0] dw;
    logic [DATA_W-1:0] dr;
    logic ack;
    logic hang;
    logic pos_up;
    logic pos_down;
    logic out_en;
    logic compare_pulse;
    logic [ATTR_W-1:0] attr;
    logic [POS_W-1:0] pos;
    logic irq;
    int fails;
    int check_count;
    initial mclk = 1'b0;
    always #25 mclk = ~mclk;
    position_sync_output_unit i_dut
    (
        .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
        .pos_up(pos_up), .pos_down(pos_down), .compare_out_en(out_en),
        .compare_pulse(compare_pulse), .compare_attr(attr), .current_position(pos),
        .irq(irq)
    );
    host_model i_host
    (
        .mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
        .dat_w(dw), .dat_r(dr), .ack(ack), .hang(hang)
    );
    task automatic end_sim();
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic rchk(input string nm, input logic [IDX_W-1:0] idx,
        input logic [31:0] m, input logic [31:0] e);
        logic [DATA_W-1:0] q;
        i_host.rd(idx, q);
        chk(nm, e, q & m);
    endtask
    // one count pulse, then watch a few edges for the match pulse
    task automatic step_up(output logic hit);
        hit = 1'b0;
        @(posedge mclk);
        pos_up <= 1'b1;
        @(posedge mclk);
        pos_up <= 1'b0;
        repeat (3)
        begin
            @(posedge mclk);
            #1;
            if (compare_pulse === 1'b1)
                hit = 1'b1;
        end
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_defaults();
        for (int n = 0; n < 2 * NUM_POINTS; n++)
            rchk("point", IDX_W'(IDX_POINT_BASE + n), 32'hffff_ffff, 32'h0);
        rchk("status", IDX_STATUS, 32'h0000_0007, 32'h0);
        i_host.wr(IDX_TARGET_POINT, 32'h0000_0009);
        rchk("point ro", IDX_TARGET_POINT, 32'h0000_ffff, 32'h4);
        rchk("unmapped", 16'h3050, 32'hffff_ffff, 32'h0);
    endtask
    task automatic t_attr();
        i_host.wr(IDX_W'(IDX_POINT_BASE + 6), 32'h0000_0006);
        i_host.wr(IDX_W'(IDX_POINT_BASE + 6), 32'h0000_0007);
        rchk("attr max", IDX_W'(IDX_POINT_BASE + 6), 32'h0000_0007, 32'h6);
        i_host.wr(IDX_W'(IDX_POINT_END - 1), 32'h8000_0000);
        rchk("target", IDX_W'(IDX_POINT_END - 1), 32'hffff_ffff, 32'h8000_0000);
    endtask
    task automatic t_sequence();
        logic hit;
        i_host.wr(IDX_IRQ_MASK, 32'h0000_0002);
        i_host.wr(IDX_MODE, 32'h0000_0001);
        for (int n = 0; n < NUM_POINTS; n++)
        begin
            i_host.wr(IDX_W'(IDX_POINT_BASE + 2 * n), 32'(n % 7));
            i_host.wr(IDX_W'(IDX_POINT_BASE + 2 * n + 1), 32'h0000_0001);
        end
        i_host.trig(CTRL_ENABLE_BIT);
        rchk("running", IDX_STATUS, 32'h0000_0001, 32'h1);
        rchk("first point", IDX_TARGET_POINT, 32'h0000_ffff, 32'h4);
        for (int n = 0; n < NUM_POINTS; n++)
        begin
            step_up(hit);
            chk("match", 32'h1, {31'h0, hit});
            chk("attr", 32'(n % 7), {29'h0, attr});
            chk("restart", 32'h0, pos);
            if (n < NUM_POINTS - 1)
                rchk("next", IDX_TARGET_POINT, 32'h0000_ffff, 32'(n + 5));
        end
        chk("auto off", 32'h0, {31'h0, out_en});
        rchk("run clear", IDX_STATUS, 32'h0000_0001, 32'h0);
        chk("irq up", 32'h1, {31'h0, irq});
        rchk("irq status", IDX_IRQ_STATUS, 32'h0000_0003, 32'h3);
        chk("irq down", 32'h0, {31'h0, irq});
    endtask
    task automatic t_origin_adjust();
        i_host.wr(IDX_MODE, 32'h0000_0000);
        i_host.wr(IDX_ORIGIN_BIAS, 32'h0000_1234);
        i_host.trig(CTRL_ORIGIN_BIT);
        chk("origin", 32'h0000_1234, pos);
        rchk("origin done", IDX_STATUS, 32'h0000_0007, 32'h2);
        chk("masked irq", 32'h0, {31'h0, irq});
        i_host.wr(IDX_ADJUST, 32'h0000_fff0);
        i_host.trig(CTRL_ADJUST_BIT);
        chk("adjust", 32'h0001_1224, pos);
        rchk("adjust done", IDX_STATUS, 32'h0000_0007, 32'h4);
        i_host.wr(IDX_CONTROL, 32'h0000_0000);
        rchk("done clear", IDX_STATUS, 32'h0000_0007, 32'h0);
        rchk("pos low", IDX_POSITION, 32'h0000_ffff, 32'h1224);
        @(posedge mclk);
        pos_down <= 1'b1;
        @(posedge mclk);
        pos_down <= 1'b0;
        @(posedge mclk);
        #1;
        chk("down", 32'h0001_1223, pos);
    endtask
    task automatic t_absolute();
        logic hit;
        i_host.wr(IDX_POINT_BASE, 32'h0000_0005);
        i_host.wr(IDX_W'(IDX_POINT_BASE + 1), 32'h0001_1225);
        i_host.trig(CTRL_ENABLE_BIT);
        step_up(hit);
        chk("early", 32'h0, {31'h0, hit});
        step_up(hit);
        chk("hit", 32'h1, {31'h0, hit});
        chk("hit attr", 32'h5, {29'h0, attr});
        rchk("advance", IDX_TARGET_POINT, 32'h0000_ffff, 32'h5);
        i_host.wr(IDX_CONTROL, 32'h0000_0000);
        chk("off", 32'h0, {31'h0, out_en});
        rchk("off status", IDX_STATUS, 32'h0000_0001, 32'h0);
        step_up(hit);
        chk("idle", 32'h0, {31'h0, hit});
    endtask
    initial
    begin
        fails = 0;
        check_count = 0;
        rst_n = 1'b0;
        pos_up = 1'b0;
        pos_down = 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        t_defaults();
        t_attr();
        t_sequence();
        t_origin_adjust();
        t_absolute();
        end_sim();
    end
    always @(posedge mclk)
        if (hang === 1'b1)
        begin
            fails++;
            end_sim();
        end
endmodule
